// ==== include/bdx_pkg.sv ====
package bdx_pkg;

    // Bus geometry and register byte offsets.
    localparam int unsigned DATA_W = 32;
    localparam int unsigned PADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WORK = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_BANK = 8'h0c;
    localparam logic [7:0] OFS_FILE = 8'h10;
    localparam logic [7:0] OFS_INDEX = 8'h14;
    localparam logic [7:0] OFS_INSTR = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1c;
    localparam logic [7:0] OFS_ADDR = 8'h20;

    // Quarter phases of one instruction cycle.
    localparam logic [1:0] Q_DECODE = 2'h0;
    localparam logic [1:0] Q_READ = 2'h1;
    localparam logic [1:0] Q_PROC = 2'h2;
    localparam logic [1:0] Q_WRITE = 2'h3;

    // Opcode patterns.
    localparam logic [15:0] OP_DECADJ = 16'h0007;
    localparam logic [6:0] OP_CMPLT_HI = 7'h30;
    localparam logic [5:0] OP_DEC_HI = 6'h01;
    localparam int unsigned OP_A_BIT = 8;
    localparam int unsigned OP_D_BIT = 9;

    // Arithmetic and addressing constants.
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;
    localparam logic [7:0] INDEXED_MAX = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [5:0] ACCESS_LO_BANK = 6'h00;
    localparam logic [5:0] ACCESS_HI_BANK = 6'h3f;
    localparam logic [7:0] SIGN_ONLY = 8'h80;
    localparam logic [1:0] CTRL_RESET = 2'h1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_EXEC = 2'b10,
        ST_SKIP = 2'b11
    } bdx_state_type;

    typedef struct packed {
        logic n;
        logic overflow;
        logic z;
        logic digit_carry;
        logic c;
    } bdx_flags_type;

    typedef struct packed {
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
        logic [1:0]    q;
        bdx_state_type state;
        logic          ext_en;
        logic [1:0]    next_words;
        logic [7:0]    work_reg;
        bdx_flags_type flags;
        logic [5:0]    bank_sel;
        logic [7:0]    file_data;
        logic [13:0]   idx_base;
        logic [15:0]   opcode;
        logic [7:0]    operand;
        logic [7:0]    result;
        bdx_flags_type res_flags;
        logic          less;
        logic [1:0]    nop_left;
        logic [13:0]   eff_addr;
        logic          skipped;
        logic          file_wr;
        logic          unknown;
    } bdx_core_type;

endpackage

// ==== hw/bdx_exec.sv ====
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Compare-less skips next when file below W
// - Skipping two-word follower costs three cycles total
// - Skipping three-word follower costs four cycles total
// - No skip: one cycle, no write, continue
// - High nibble plus six if above nine/C
// - Decimal adjust: read W, write W, carry only
// - Decrement file; destination bit picks W or file
// - Decrement one cycle, updates all five flags
// - Access bit zero: access bank, one: bank register
// - Extended set, access zero, f<=95: indexed offset
module bdx_exec (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata
);

    bdx_pkg::bdx_core_type cur;
    bdx_pkg::bdx_core_type nxt;
    logic                  acc;
    logic                  idle;
    logic                  is_cmp;
    logic                  is_adj;
    logic                  is_dec;
    logic [7:0]            f_sel;
    logic                  lo_fix;
    logic                  hi_fix;
    logic [8:0]            sum_lo;
    logic [8:0]            sum_hi;
    logic [7:0]            dec_val;

    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign prdata = cur.prdata;

    // Next-state logic for the bus slave, the phase divider and execution.
    always_comb begin
        nxt = cur;
        acc = psel & penable & ~cur.pready;
        idle = (cur.state == bdx_pkg::ST_IDLE);
        f_sel = cur.opcode[7:0];
        is_cmp = (cur.opcode[15:9] == bdx_pkg::OP_CMPLT_HI);
        is_adj = (cur.opcode == bdx_pkg::OP_DECADJ);
        is_dec = (cur.opcode[15:10] == bdx_pkg::OP_DEC_HI);
        lo_fix = 1'b0;
        hi_fix = 1'b0;
        sum_lo = '0;
        sum_hi = '0;
        dec_val = cur.operand - 8'h01;

        // The quarter counter is the one-in-four enable of the core.
        nxt.q = cur.q + 2'h1;
        nxt.pready = acc;
        nxt.pslverr = 1'b0;

        // Bus writes to registers only land while idle so an instruction sees stable data.
        if (acc) begin
            nxt.prdata = '0;
            case (paddr)
                bdx_pkg::OFS_CTRL: begin
                    nxt.prdata = {29'h0, cur.next_words, cur.ext_en};
                    if (pwrite && idle) begin
                        nxt.ext_en = pwdata[0];
                        nxt.next_words = pwdata[2:1];
                    end
                end
                bdx_pkg::OFS_WORK: begin
                    nxt.prdata = {24'h0, cur.work_reg};
                    if (pwrite && idle) nxt.work_reg = pwdata[7:0];
                end
                bdx_pkg::OFS_FLAGS: begin
                    nxt.prdata = {27'h0, cur.flags};
                    if (pwrite && idle) nxt.flags = pwdata[4:0];
                end
                bdx_pkg::OFS_BANK: begin
                    nxt.prdata = {26'h0, cur.bank_sel};
                    if (pwrite && idle) nxt.bank_sel = pwdata[5:0];
                end
                bdx_pkg::OFS_FILE: begin
                    nxt.prdata = {24'h0, cur.file_data};
                    if (pwrite && idle) nxt.file_data = pwdata[7:0];
                end
                bdx_pkg::OFS_INDEX: begin
                    nxt.prdata = {18'h0, cur.idx_base};
                    if (pwrite && idle) nxt.idx_base = pwdata[13:0];
                end
                bdx_pkg::OFS_INSTR: begin
                    nxt.prdata = {16'h0, cur.opcode};
                    if (pwrite && idle) begin
                        nxt.opcode = pwdata[15:0];
                        nxt.state = bdx_pkg::ST_WAIT;
                        nxt.skipped = 1'b0;
                        nxt.file_wr = 1'b0;
                        nxt.unknown = 1'b0;
                    end
                end
                bdx_pkg::OFS_STAT: begin
                    nxt.prdata = {28'h0, cur.unknown, cur.file_wr,
                                  cur.skipped, ~idle};
                end
                bdx_pkg::OFS_ADDR: begin
                    nxt.prdata = {18'h0, cur.eff_addr};
                end
                default: nxt.pslverr = 1'b1;
            endcase
        end

        // Packed BCD correction, carried as two byte-wide additions.
        lo_fix = (cur.operand[3:0] > bdx_pkg::BCD_MAX)
               | cur.flags.digit_carry;
        sum_lo = {1'b0, cur.operand}
               + (lo_fix ? {5'h0, bdx_pkg::BCD_FIX} : 9'h000);
        hi_fix = (({1'b0, cur.operand[7:4]} + {4'h0, cur.flags.digit_carry})
                 > {1'b0, bdx_pkg::BCD_MAX}) | cur.flags.c;
        sum_hi = sum_lo
               + (hi_fix ? {1'b0, bdx_pkg::BCD_FIX, 4'h0} : 9'h000);

        unique case (cur.state)
            bdx_pkg::ST_IDLE: begin
            end
            // A new instruction starts on the next decode quarter.
            bdx_pkg::ST_WAIT: begin
                if (cur.q == bdx_pkg::Q_WRITE) nxt.state = bdx_pkg::ST_EXEC;
            end
            bdx_pkg::ST_EXEC: begin
                case (cur.q)
                    // Decode resolves the operand address.
                    bdx_pkg::Q_DECODE: begin
                        if (!cur.opcode[bdx_pkg::OP_A_BIT]) begin
                            if (cur.ext_en && f_sel <= bdx_pkg::INDEXED_MAX)
                                nxt.eff_addr = cur.idx_base
                                             + {6'h00, f_sel};
                            else if (f_sel < bdx_pkg::ACCESS_SPLIT)
                                nxt.eff_addr = {bdx_pkg::ACCESS_LO_BANK,
                                                f_sel};
                            else
                                nxt.eff_addr = {bdx_pkg::ACCESS_HI_BANK,
                                                f_sel};
                        end else begin
                            nxt.eff_addr = {cur.bank_sel, f_sel};
                        end
                    end
                    // The adjust reads W, the others the file operand.
                    bdx_pkg::Q_READ: begin
                        nxt.operand = is_adj ? cur.work_reg
                                             : cur.file_data;
                    end
                    bdx_pkg::Q_PROC: begin
                        nxt.less = cur.operand < cur.work_reg;
                        nxt.res_flags = cur.flags;
                        if (is_adj) begin
                            nxt.result = sum_hi[7:0];
                            nxt.res_flags.c = sum_lo[8] | sum_hi[8]
                                            | cur.flags.c;
                        end else begin
                            nxt.result = dec_val;
                            nxt.res_flags.c = (cur.operand != 8'h00);
                            nxt.res_flags.digit_carry
                                = (cur.operand[3:0] != 4'h0);
                            nxt.res_flags.z = (dec_val == 8'h00);
                            nxt.res_flags.n = dec_val[7];
                            nxt.res_flags.overflow = (cur.operand
                                             == bdx_pkg::SIGN_ONLY);
                        end
                    end
                    // Only the write quarter touches stored data.
                    bdx_pkg::Q_WRITE: begin
                        nxt.state = bdx_pkg::ST_IDLE;
                        if (is_adj) begin
                            nxt.work_reg = cur.result;
                            nxt.flags.c = cur.res_flags.c;
                        end else if (is_dec) begin
                            nxt.flags = cur.res_flags;
                            if (cur.opcode[bdx_pkg::OP_D_BIT]) begin
                                nxt.file_data = cur.result;
                                nxt.file_wr = 1'b1;
                            end else begin
                                nxt.work_reg = cur.result;
                            end
                        end else if (is_cmp) begin
                            // Compare writes nothing; it may only skip.
                            if (cur.less) begin
                                nxt.state = bdx_pkg::ST_SKIP;
                                nxt.skipped = 1'b1;
                                nxt.nop_left = (cur.next_words == 2'h0)
                                             ? 2'h1
                                             : cur.next_words;
                            end
                        end else begin
                            nxt.unknown = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // One idle instruction cycle per word of the discarded follower.
            bdx_pkg::ST_SKIP: begin
                if (cur.q == bdx_pkg::Q_WRITE) begin
                    if (cur.nop_left == 2'h1)
                        nxt.state = bdx_pkg::ST_IDLE;
                    else
                        nxt.nop_left = cur.nop_left - 2'h1;
                end
            end
        endcase
    end

    // The whole state registers here; reset gives a defined idle core.
    always_ff @(posedge clock) begin
        if (reset) begin
            cur <= '0;
            cur.state <= bdx_pkg::ST_IDLE;
            cur.next_words <= bdx_pkg::CTRL_RESET;
        end else begin
            cur <= nxt;
        end
    end

endmodule // bdx_exec

`default_nettype wire

// ==== dv/bdx_exec_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

// Port-level checks on the register bus of the execution block.
module bdx_exec_assertions (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // A transfer is taken in its first access cycle, before any answer.
    sequence s_taken;
        psel && penable && !pready;
    endsequence
    sequence s_read(logic [7:0] a);
        s_taken ##0 (!pwrite && paddr == a);
    endsequence

    chk_answer_next: assert property (s_taken |=> pready)
        else $error("answer missing one cycle after access");
    chk_pready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    chk_pready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready without an access");
    chk_err_unmapped: assert property (s_taken ##0
        (paddr > bdx_pkg::OFS_ADDR && paddr[1:0] == 2'h0)
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (s_taken ##0
        (paddr <= bdx_pkg::OFS_ADDR && paddr[1:0] == 2'h0) |=> !pslverr)
        else $error("mapped access refused");
    chk_err_qualified: assert property (pslverr |-> pready)
        else $error("error response outside an answer");
    chk_stat_width: assert property (s_read(bdx_pkg::OFS_STAT)
        |=> prdata[31:4] == 28'h0)
        else $error("status upper bits not zero");
    chk_flags_width: assert property (s_read(bdx_pkg::OFS_FLAGS)
        |=> prdata[31:5] == 27'h0)
        else $error("flag upper bits not zero");
endmodule // bdx_exec_assertions

`default_nettype wire

// ==== dv/bdx_exec_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
 fail_count++; $display("CHECK FAILED %s exp %h got %h", what, exp, got); \
 end end

module bdx_exec_bench;
    logic        clock   = 1'b0;
    logic        reset   = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        last_err;
    logic [31:0] rdata;
    int          fail_count  = 0;
    int          num_checks  = 0;
    int          cycle_count = 0;
    logic [7:0]  adj_w [5] = '{8'ha5, 8'hce, 8'h3a, 8'h12, 8'hfa};
    logic [4:0]  adj_f [5] = '{5'h00, 5'h00, 5'h1c, 5'h02, 5'h01};

    // Eight nanosecond clock.
    always #4 clock = ~clock;

    bdx_exec uut (.clock(clock), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata));

    // Ends the run; also reached when the cycle ceiling runs out.
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // A hang would otherwise stall polling forever.
    always @(posedge clock) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 20000) begin
            fail_count++;
            conclude();
        end
    end

    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        // Besides pready, only the bench's cycle ceiling may end this wait.
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rdata = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        `CHK(what, exp, rdata)
    endtask

    // Loads every operand register before an instruction.
    task automatic setup(input logic [2:0] ctrl, input logic [7:0] w,
                         input logic [4:0] fl, input logic [5:0] bank,
                         input logic [7:0] fv);
        apb(1'b1, bdx_pkg::OFS_CTRL, {29'h0, ctrl});
        apb(1'b1, bdx_pkg::OFS_WORK, {24'h0, w});
        apb(1'b1, bdx_pkg::OFS_FLAGS, {27'h0, fl});
        apb(1'b1, bdx_pkg::OFS_BANK, {26'h0, bank});
        apb(1'b1, bdx_pkg::OFS_FILE, {24'h0, fv});
        apb(1'b1, bdx_pkg::OFS_INDEX, 32'h100);
    endtask

    // Polling is coarse, so timing is judged by the count of busy reads.
    task automatic wait_idle(output int n);
        n = 0;
        apb(1'b0, bdx_pkg::OFS_STAT, 32'h0);
        while (rdata[0] === 1'b1) begin
            n++;
            apb(1'b0, bdx_pkg::OFS_STAT, 32'h0);
        end
    endtask

    task automatic exec(input logic [15:0] op, output int n);
        apb(1'b1, bdx_pkg::OFS_INSTR, {16'h0, op});
        wait_idle(n);
    endtask

    task automatic dec_case(input logic [2:0] ctrl, input logic [7:0] fv,
                            input logic d, input logic a,
                            input logic [7:0] f, input logic [13:0] ea);
        logic [7:0] r;
        int n;
        r = fv - 8'h01;
        setup(ctrl, 8'h5a, 5'h00, 6'h15, fv);
        exec({bdx_pkg::OP_DEC_HI, d, a, f}, n);
        `CHK("dec stat", {1'b0, d, 2'b00}, rdata[3:0])
        rd_chk("dec work", bdx_pkg::OFS_WORK, d ? 32'h5a : r);
        rd_chk("dec file", bdx_pkg::OFS_FILE, d ? r : fv);
        rd_chk("dec flags", bdx_pkg::OFS_FLAGS, {r[7], fv == 8'h80,
            r == 8'h0, fv[3:0] != 4'h0, fv != 8'h0});
        rd_chk("dec addr", bdx_pkg::OFS_ADDR, ea);
    endtask

    task automatic cmp_case(input logic [7:0] fv, input logic [7:0] w,
                            input logic [1:0] words);
        int n;
        int base;
        logic less;
        less = fv < w;
        // A follower length of zero counts as one word.
        base = less ? ((words == 2'h0) ? 1 : words) : 0;
        setup({words, 1'b0}, w, 5'h15, 6'h00, fv);
        exec({bdx_pkg::OP_CMPLT_HI, 1'b0, 8'h20}, n);
        `CHK("cmp stat", {2'b00, less, 1'b0}, rdata[3:0])
        `CHK("cmp time", 1'b1, n > base && n <= base + 2)
        rd_chk("cmp work", bdx_pkg::OFS_WORK, w);
        rd_chk("cmp file", bdx_pkg::OFS_FILE, fv);
        rd_chk("cmp flags", bdx_pkg::OFS_FLAGS, 32'h15);
    endtask

    // Main sequence: reset values, refusals, then each instruction.
    initial begin
        logic [8:0] r;
        int n;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        rd_chk("ctrl reset", bdx_pkg::OFS_CTRL, 32'h2);
        rd_chk("stat reset", bdx_pkg::OFS_STAT, 32'h0);
        rd_chk("addr reset", bdx_pkg::OFS_ADDR, 32'h0);
        apb(1'b1, bdx_pkg::OFS_STAT, 32'hf);
        rd_chk("stat ro", bdx_pkg::OFS_STAT, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped err", 1'b1, last_err)
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            r = {1'b0, adj_w[i]};
            if (adj_w[i][3:0] > 4'h9 || adj_f[i][1])
                r = r + 9'h006;
            if ({1'b0, adj_w[i][7:4]} + adj_f[i][1] > 5'h9 || adj_f[i][0])
                r = r + 9'h060;
            setup(3'h2, adj_w[i], adj_f[i], 6'h00, 8'h33);
            exec(bdx_pkg::OP_DECADJ, n);
            rd_chk("adj work", bdx_pkg::OFS_WORK, r[7:0]);
            rd_chk("adj flags", bdx_pkg::OFS_FLAGS, {adj_f[i][4:1],
                r[8] | adj_f[i][0]});
        end
        $display("test decimal adjust done");
        dec_case(3'h2, 8'h01, 1'b1, 1'b1, 8'h34, 14'h1534);
        dec_case(3'h2, 8'h00, 1'b0, 1'b0, 8'h34, 14'h0034);
        dec_case(3'h2, 8'h80, 1'b0, 1'b0, 8'h80, 14'h3f80);
        dec_case(3'h3, 8'h10, 1'b1, 1'b0, 8'h5f, 14'h015f);
        dec_case(3'h3, 8'h7f, 1'b0, 1'b0, 8'h60, 14'h3f60);
        $display("test decrement done");
        // A write while busy is dropped; an unknown opcode runs as nothing.
        setup(3'h2, 8'h5a, 5'h00, 6'h00, 8'h33);
        apb(1'b1, bdx_pkg::OFS_INSTR, 32'hffff);
        apb(1'b1, bdx_pkg::OFS_WORK, 32'h11);
        wait_idle(n);
        `CHK("unknown stat", 4'h8, rdata[3:0])
        rd_chk("busy write", bdx_pkg::OFS_WORK, 32'h5a);
        $display("test unknown opcode done");
        cmp_case(8'h10, 8'h20, 2'h1);
        cmp_case(8'h01, 8'h02, 2'h0);
        cmp_case(8'h10, 8'h20, 2'h2);
        cmp_case(8'h7f, 8'h80, 2'h3);
        cmp_case(8'h20, 8'h20, 2'h3);
        cmp_case(8'hff, 8'h01, 2'h2);
        $display("test compare done");
        conclude();
    end
endmodule // bdx_exec_bench

bind bdx_exec bdx_exec_assertions chk (.clock(clock), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));

`default_nettype wire
